// *** hw/ccsc_pkg.sv ***
// Constants and types shared by the clock source control block
package ccsc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;   // 20 MHz system clock
  localparam int SETTLE_NS     = 200;  // Least settle time before a switch completes
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [1:0] RUN_CTRL_OFS = 2'h0;  // clock_run_control
  localparam logic [1:0] SYS_SEL_OFS  = 2'h1;  // system_clock_select
  localparam logic [1:0] SUB_MODE_OFS = 2'h2;  // sub_clock_supply_mode
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int X1_STOP_BIT   = 7;  // x1_osc_stop
  localparam int SUB_STOP_BIT  = 6;  // subosc_stop
  localparam int MID_EN_BIT    = 1;  // mid_osc_enable
  localparam int HIGH_STOP_BIT = 0;  // high_osc_stop
  localparam int CPU_STAT_BIT  = 7;  // cpu_clock_source_status
  localparam int CPU_SEL_BIT   = 6;  // cpu_clock_source_select
  localparam int MAIN_STAT_BIT = 5;  // main_clock_source_status
  localparam int MAIN_SEL_BIT  = 4;  // main_clock_source_select
  localparam int OCO_STAT_BIT  = 1;  // onchip_osc_source_status
  localparam int OCO_SEL_BIT   = 0;  // onchip_osc_source_select
  localparam int GATE_BIT      = 7;  // sub_clock_peripheral_gate
  localparam int ICLK_BIT      = 4;  // interval_count_clock_select
  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] RUN_RST  = 8'hC0;
  localparam logic [7:0] SEL_RST  = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] RUN_WM   = 8'hC3;
  localparam logic [7:0] SEL_WM   = 8'h51;
  localparam logic [7:0] MODE_WM  = 8'h90;
  // ----------------------------------------
  // Switch sequencer types
  // ----------------------------------------
  typedef enum logic [1:0] {SW_IDLE = 2'b00, SW_SETTLE = 2'b01} ccsc_sw_t;
  typedef enum logic [1:0] {TGT_OCO = 2'b00, TGT_MAIN = 2'b01, TGT_CPU = 2'b10} ccsc_tgt_t;
endpackage

// *** hw/ccsc_top.sv ***
// Clock source control: run/stop, source selection, switch status and sub clock gating
`timescale 1ns/1ns
module ccsc_top
  import ccsc_pkg::*;
#(
  parameter int SETTLE_COUNT = SETTLE_CYC  // Cycles a switch waits on a running source
) (
  // Clock, reset, enable
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // Register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Standby state of the CPU
  input  wire logic       stop_mode,
  input  wire logic       halt_mode,
  // Oscillator run controls
  output logic            x1_osc_run,
  output logic            sub_osc_run,
  output logic            mid_osc_run,
  output logic            high_osc_run,
  // Clock multiplexer controls, following status
  output logic            cpu_clk_from_sub,
  output logic            main_clk_from_x1,
  output logic            onchip_from_mid,
  // Peripheral clock controls
  output logic            sub_periph_clk_en,
  output logic            interval_clk_lowspeed
);

  // The settle counter is eight bits; zero would wrap it into a long wait
  if (SETTLE_COUNT < 1 || SETTLE_COUNT > 255) begin : g_bad_settle
    $error("SETTLE_COUNT must lie in 1..255");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Masked write: fixed-zero positions never take data
  function automatic logic [7:0] wr_field(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] wm, input logic hit);
    wr_field = hit ? (wd & wm) : old;
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] run_ff,  nxt_run;   // clock_run_control
  logic [7:0] sel_ff,  nxt_sel;   // Writable select bits of system_clock_select
  logic [7:0] mode_ff, nxt_mode;  // sub_clock_supply_mode
  logic [7:0] rdata_ff, nxt_rdata; // Read data, valid one cycle after the strobe
  logic       cpu_stat_ff;        // CPU clock source in use (1 = subsystem)
  logic       main_stat_ff;       // Main clock source in use (1 = high-speed system)
  logic       oco_stat_ff;        // On-chip source in use (1 = middle-speed)
  logic [7:0] sel_view;           // Full select register as software sees it
  logic [7:0] live_mask;          // Bits of the addressed register that may read as one

  // Status bits sit beside the select bits they track; the select bits show the
  // request at once, the status bits only once the switch has really happened
  assign sel_view = {cpu_stat_ff, sel_ff[CPU_SEL_BIT], main_stat_ff, sel_ff[MAIN_SEL_BIT],
                     2'b00, oco_stat_ff, sel_ff[OCO_SEL_BIT]};

  // Next values of the registers and the read data
  always_comb begin
    nxt_run   = wr_field(run_ff, reg_wdata, RUN_WM, reg_wr && reg_addr == RUN_CTRL_OFS);
    nxt_sel   = wr_field(sel_ff, reg_wdata, SEL_WM, reg_wr && reg_addr == SYS_SEL_OFS);
    nxt_mode  = wr_field(mode_ff, reg_wdata, MODE_WM, reg_wr && reg_addr == SUB_MODE_OFS);
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        RUN_CTRL_OFS: nxt_rdata = run_ff;
        SYS_SEL_OFS:  nxt_rdata = sel_view;
        SUB_MODE_OFS: nxt_rdata = mode_ff;
        default:      nxt_rdata = 8'h00;     // Unmapped index reads zero
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      run_ff   <= RUN_RST;
      sel_ff   <= SEL_RST;
      mode_ff  <= MODE_RST;
      rdata_ff <= 8'h00;
    end else if (clk_en) begin
      run_ff   <= nxt_run;
      sel_ff   <= nxt_sel;
      mode_ff  <= nxt_mode;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------
  // Switch sequencer
  // ----------------------------------------
  // One switch at a time; on-chip first, then main, then CPU, so a chain
  // of requests completes from the bottom of the clock tree upward.
  ccsc_sw_t   state_ff, nxt_state;
  ccsc_tgt_t  tgt_ff,   nxt_tgt;
  logic [7:0] cnt_ff,   nxt_cnt;
  logic       nxt_cpu_stat, nxt_main_stat, nxt_oco_stat;
  logic       oco_ok, main_ok, cpu_ok, tgt_ok;

  always_comb begin
    // A target source must be running before the switch may start, except the CPU switch back to main
    oco_ok  = sel_ff[OCO_SEL_BIT] ? run_ff[MID_EN_BIT] : !run_ff[HIGH_STOP_BIT];
    // Back to on-chip needs the on-chip oscillator now in use to be running
    main_ok = sel_ff[MAIN_SEL_BIT] ? !run_ff[X1_STOP_BIT]
                                   : (oco_stat_ff ? run_ff[MID_EN_BIT] : !run_ff[HIGH_STOP_BIT]);
    cpu_ok  = sel_ff[CPU_SEL_BIT] ? !run_ff[SUB_STOP_BIT] : 1'b1;
    case (tgt_ff)
      TGT_OCO:  tgt_ok = oco_ok  && (oco_stat_ff  != sel_ff[OCO_SEL_BIT]);
      TGT_MAIN: tgt_ok = main_ok && (main_stat_ff != sel_ff[MAIN_SEL_BIT]);
      TGT_CPU:  tgt_ok = cpu_ok  && (cpu_stat_ff  != sel_ff[CPU_SEL_BIT]);
      default:  tgt_ok = 1'b0;
    endcase
    nxt_state     = state_ff;
    nxt_tgt       = tgt_ff;
    nxt_cnt       = cnt_ff;
    nxt_cpu_stat  = cpu_stat_ff;
    nxt_main_stat = main_stat_ff;
    nxt_oco_stat  = oco_stat_ff;
    case (state_ff)
      SW_IDLE: begin
        nxt_cnt = 8'(SETTLE_COUNT - 1);
        if (oco_stat_ff != sel_ff[OCO_SEL_BIT] && oco_ok) begin
          nxt_tgt   = TGT_OCO;
          nxt_state = SW_SETTLE;
        end else if (main_stat_ff != sel_ff[MAIN_SEL_BIT] && main_ok) begin
          nxt_tgt   = TGT_MAIN;
          nxt_state = SW_SETTLE;
        end else if (cpu_stat_ff != sel_ff[CPU_SEL_BIT] && cpu_ok) begin
          nxt_tgt   = TGT_CPU;
          nxt_state = SW_SETTLE;
        end
      end
      SW_SETTLE: begin
        if (!tgt_ok) begin
          // Select reverted or source stopped: abandon, status unchanged
          nxt_state = SW_IDLE;
        end else if (cnt_ff == 8'h00) begin
          nxt_state = SW_IDLE;
          case (tgt_ff)
            TGT_OCO:  nxt_oco_stat  = sel_ff[OCO_SEL_BIT];
            TGT_MAIN: nxt_main_stat = sel_ff[MAIN_SEL_BIT];
            TGT_CPU:  nxt_cpu_stat  = sel_ff[CPU_SEL_BIT];
            default:  nxt_cpu_stat  = cpu_stat_ff;
          endcase
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: nxt_state = SW_IDLE;
    endcase
  end

  // Sequencer storage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= SW_IDLE;
      tgt_ff   <= TGT_OCO;
      cnt_ff   <= 8'h00;
      cpu_stat_ff  <= 1'b0;
      main_stat_ff <= 1'b0;
      oco_stat_ff  <= 1'b0;
    end else if (clk_en) begin
      state_ff     <= nxt_state;
      tgt_ff       <= nxt_tgt;
      cnt_ff       <= nxt_cnt;
      cpu_stat_ff  <= nxt_cpu_stat;
      main_stat_ff <= nxt_main_stat;
      oco_stat_ff  <= nxt_oco_stat;
    end
  end

  // Multiplexers follow status, never the raw select, to avoid glitching
  assign cpu_clk_from_sub = cpu_stat_ff;
  assign main_clk_from_x1 = main_stat_ff;
  assign onchip_from_mid  = oco_stat_ff;

  // ----------------------------------------
  // Oscillator and peripheral clock controls
  // ----------------------------------------
  logic [3:0] osc_run_ff, nxt_osc_run;  // x1, sub, mid, high
  logic       periph_ff,  nxt_periph;
  logic       iclk_ff,    nxt_iclk;

  // Stopping a source in use is not blocked; software must switch away first
  // Decode run bits and standby gating
  always_comb begin
    nxt_osc_run = {!nxt_run[X1_STOP_BIT],
                   !nxt_run[SUB_STOP_BIT],
                   nxt_run[MID_EN_BIT],
                   !nxt_run[HIGH_STOP_BIT]};
    // Sub clock held back in STOP, or in HALT while the CPU runs on it
    nxt_periph = !(mode_ff[GATE_BIT] && (stop_mode || (halt_mode && cpu_stat_ff)));
    nxt_iclk   = nxt_mode[ICLK_BIT];
  end

  // Control output storage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      osc_run_ff <= 4'h1;
      periph_ff  <= 1'b1;
      iclk_ff    <= 1'b0;
    end else if (clk_en) begin
      osc_run_ff <= nxt_osc_run;
      periph_ff  <= nxt_periph;
      iclk_ff    <= nxt_iclk;
    end
  end

  assign x1_osc_run            = osc_run_ff[3];
  assign sub_osc_run           = osc_run_ff[2];
  assign mid_osc_run           = osc_run_ff[1];
  assign high_osc_run          = osc_run_ff[0];
  assign sub_periph_clk_en     = periph_ff;
  assign interval_clk_lowspeed = iclk_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic run_wr, sel_rd;
  assign run_wr = clk_en && reg_wr && reg_addr == RUN_CTRL_OFS;
  assign sel_rd = clk_en && reg_rd && reg_addr == SYS_SEL_OFS;

  // Bits of the addressed register that may ever read as one
  always_comb begin
    case (reg_addr)
      RUN_CTRL_OFS: live_mask = RUN_WM;
      SYS_SEL_OFS:  live_mask = SEL_WM | (8'h01 << CPU_STAT_BIT) | (8'h01 << MAIN_STAT_BIT)
                              | (8'h01 << OCO_STAT_BIT);
      SUB_MODE_OFS: live_mask = MODE_WM;
      default:      live_mask = 8'h00;
    endcase
  end

  chk_sub_osc_run: assert property (run_wr |=> sub_osc_run == !$past(reg_wdata[SUB_STOP_BIT]))
    else $error("sub oscillator run wrong");
  chk_mid_osc_run: assert property (run_wr |=> mid_osc_run == $past(reg_wdata[MID_EN_BIT]))
    else $error("mid oscillator run wrong");
  chk_high_osc_run: assert property (run_wr |=> high_osc_run == !$past(reg_wdata[HIGH_STOP_BIT]))
    else $error("high oscillator run wrong");
  chk_x1_osc_run: assert property (run_wr |=> x1_osc_run == !$past(reg_wdata[X1_STOP_BIT]))
    else $error("main crystal run wrong");
  // Status takes the select value that stood on the completing edge, even if
  // software rewrites the select on that very edge
  chk_cpu_switch: assert property ($changed(cpu_clk_from_sub) |->
    cpu_clk_from_sub == $past(sel_ff[CPU_SEL_BIT]) && $past(state_ff) == SW_SETTLE)
    else $error("cpu clock switched wrongly");
  chk_main_switch: assert property ($changed(main_clk_from_x1) |->
    main_clk_from_x1 == $past(sel_ff[MAIN_SEL_BIT]) && $past(tgt_ff) == TGT_MAIN)
    else $error("main clock switched wrongly");
  chk_oco_switch: assert property ($changed(onchip_from_mid) |->
    onchip_from_mid == $past(sel_ff[OCO_SEL_BIT]) && $past(cnt_ff) == 8'h00)
    else $error("on-chip source switched wrongly");
  chk_status_read: assert property (sel_rd |=> reg_rdata[CPU_STAT_BIT] == $past(cpu_stat_ff) &&
    reg_rdata[MAIN_STAT_BIT] == $past(main_stat_ff) && reg_rdata[OCO_STAT_BIT] == $past(oco_stat_ff))
    else $error("status readback wrong");
  chk_settle_wait: assert property (state_ff == SW_SETTLE && cnt_ff != 8'h00 |=>
    $stable(cpu_clk_from_sub) && $stable(main_clk_from_x1) && $stable(onchip_from_mid))
    else $error("status moved before settling ended");
  // A stopped target must hold its status however long software waits
  chk_oco_wait: assert property (!oco_ok |=> $stable(onchip_from_mid))
    else $error("on-chip source switched to a stopped oscillator");
  chk_main_wait: assert property (!main_ok |=> $stable(main_clk_from_x1))
    else $error("main clock switched to a stopped source");
  chk_fixed_zero: assert property (clk_en && reg_rd |=>
    (reg_rdata & ~$past(live_mask)) == 8'h00)
    else $error("fixed-zero bits read nonzero");
  chk_sub_gate: assert property (clk_en && mode_ff[GATE_BIT] && stop_mode |=> !sub_periph_clk_en)
    else $error("sub clock not gated in stop");
  chk_iclk_sel: assert property (clk_en && reg_wr && reg_addr == SUB_MODE_OFS |=>
    interval_clk_lowspeed == $past(reg_wdata[ICLK_BIT]))
    else $error("interval clock select wrong");

  cov_cpu_to_sub:  cover property ($rose(cpu_clk_from_sub));
  cov_main_to_x1:  cover property ($rose(main_clk_from_x1));
  cov_oco_to_high: cover property ($fell(onchip_from_mid));
  cov_switch_drop: cover property (state_ff == SW_SETTLE && !tgt_ok);
  cov_halt_gate:   cover property (halt_mode && cpu_stat_ff && !sub_periph_clk_en);

endmodule

// *** sim/cpu_clock_source_control_bench.sv ***
// Self-checking bench for the clock source control block
`timescale 1ns/1ns
module cpu_clock_source_control_bench;
  import ccsc_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       clock     = 1'b0;  // 20 MHz system clock
  logic       sys_rst   = 1'b1;  // Held high for the first cycles
  logic       clk_en    = 1'b1;  // Advance enable
  logic [1:0] reg_addr  = 2'h0;  // Register index
  logic [7:0] reg_wdata = 8'h00; // Write data
  logic       reg_wr    = 1'b0;  // Write strobe
  logic       reg_rd    = 1'b0;  // Read strobe
  logic       stop_mode = 1'b0;  // CPU standby levels
  logic       halt_mode = 1'b0;
  logic [7:0] reg_rdata;
  logic       x1_osc_run, sub_osc_run, mid_osc_run, high_osc_run;
  logic       cpu_clk_from_sub, main_clk_from_x1, onchip_from_mid;
  logic       sub_periph_clk_en, interval_clk_lowspeed;
  int         bad_count = 0;     // Mismatches seen
  int         n_checks  = 0;     // Comparisons made
  // ----------------------------------------
  // Clock and device
  // ----------------------------------------
  always #25 clock = ~clock;
  ccsc_top #(.SETTLE_COUNT(4)) dut (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stop_mode(stop_mode), .halt_mode(halt_mode),
    .x1_osc_run(x1_osc_run), .sub_osc_run(sub_osc_run), .mid_osc_run(mid_osc_run),
    .high_osc_run(high_osc_run), .cpu_clk_from_sub(cpu_clk_from_sub),
    .main_clk_from_x1(main_clk_from_x1), .onchip_from_mid(onchip_from_mid),
    .sub_periph_clk_en(sub_periph_clk_en), .interval_clk_lowspeed(interval_clk_lowspeed));
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  // One-cycle write strobe; returns just after the taking edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Compare any value up to eight bits
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Read strobe; data is sampled in the single cycle after it
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg%0d", a), exp, reg_rdata);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, run outputs after reset, unmapped index
  task automatic t_reset;
    chk("run_out", 8'h01, {x1_osc_run, sub_osc_run, mid_osc_run, high_osc_run});
    rd_chk(RUN_CTRL_OFS, 8'hC0);
    rd_chk(SYS_SEL_OFS, 8'h00);
    rd_chk(SUB_MODE_OFS, 8'h00);
    rd_chk(2'h3, 8'h00);
    $display("test reset done");
  endtask
  // Run controls, fixed-zero bits, frozen write
  task automatic t_run;
    wr(RUN_CTRL_OFS, 8'h03);
    ticks(1);
    chk("run_out", 8'h0E, {x1_osc_run, sub_osc_run, mid_osc_run, high_osc_run});
    wr(RUN_CTRL_OFS, 8'hFF);
    ticks(1);
    chk("run_out", 8'h02, {x1_osc_run, sub_osc_run, mid_osc_run, high_osc_run});
    rd_chk(RUN_CTRL_OFS, 8'hC3);
    clk_en <= 1'b0;
    wr(RUN_CTRL_OFS, 8'h00);
    clk_en <= 1'b1;
    rd_chk(RUN_CTRL_OFS, 8'hC3);
    wr(RUN_CTRL_OFS, 8'h03);
    ticks(1);
    chk("run_out", 8'h0E, {x1_osc_run, sub_osc_run, mid_osc_run, high_osc_run});
    wr(2'h3, 8'hFF);
    rd_chk(RUN_CTRL_OFS, 8'h03);
    $display("test run done");
  endtask
  // Select write, status lags until the switch completes
  task automatic t_switch(input logic [7:0] sel, input int bitpos, input logic [7:0] rb);
    logic [2:0] st;
    wr(SYS_SEL_OFS, sel);
    ticks(4);
    st = {cpu_clk_from_sub, main_clk_from_x1, onchip_from_mid};
    chk("status_early", 8'h00, {7'h00, st[bitpos]});
    // Exactly SETTLE_COUNT edges after the sequencer leaves idle
    ticks(1);
    st = {cpu_clk_from_sub, main_clk_from_x1, onchip_from_mid};
    chk("status_late", 8'h01, {7'h00, st[bitpos]});
    rd_chk(SYS_SEL_OFS, rb);
    $display("test switch %0d done", bitpos);
  endtask
  // Peripheral gating in standby and count clock choice
  task automatic t_gate;
    halt_mode <= 1'b1;
    ticks(2);
    chk("periph_en", 8'h01, {7'h00, sub_periph_clk_en});
    wr(SUB_MODE_OFS, 8'hFF);
    ticks(1);
    chk("periph_en", 8'h00, {7'h00, sub_periph_clk_en});
    chk("iclk", 8'h01, {7'h00, interval_clk_lowspeed});
    rd_chk(SUB_MODE_OFS, 8'h90);
    halt_mode <= 1'b0;
    ticks(2);
    chk("periph_en", 8'h01, {7'h00, sub_periph_clk_en});
    stop_mode <= 1'b1;
    ticks(2);
    chk("periph_en", 8'h00, {7'h00, sub_periph_clk_en});
    wr(SUB_MODE_OFS, 8'h00);
    ticks(1);
    chk("periph_en", 8'h01, {7'h00, sub_periph_clk_en});
    chk("iclk", 8'h00, {7'h00, interval_clk_lowspeed});
    stop_mode <= 1'b0;
    $display("test gate done");
  endtask
  // Switch waits while its target is stopped, then runs on-chip first, main next
  task automatic t_blocked;
    wr(RUN_CTRL_OFS, 8'h01);
    wr(SYS_SEL_OFS, 8'h40);
    ticks(8);
    rd_chk(SYS_SEL_OFS, 8'hE2);
    wr(RUN_CTRL_OFS, 8'h00);
    ticks(12);
    rd_chk(SYS_SEL_OFS, 8'hC0);
    $display("test blocked done");
  endtask
  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_run();
    t_switch(8'h01, 0, 8'h03);
    t_switch(8'h11, 1, 8'h33);
    t_switch(8'h51, 2, 8'hF3);
    wr(SYS_SEL_OFS, 8'hFF);
    rd_chk(SYS_SEL_OFS, 8'hF3);
    t_gate();
    t_blocked();
    conclude();
  end
  // Watchdog: the sequence needs about 110 cycles; the limit of 3000 is over twenty-five times that
  initial begin
    #(50 * 3000);
    bad_count++;
    conclude();
  end
endmodule
